// ==== tmc_pkg.sv ====
// Summary of operation
// - PC/PFC PWM modes, action 00 disconnects output; pin keeps port function.
// - PC family, action 10 clears on up-count match, sets on down-count.
// - PC family, action 11 sets on up-count match, clears on down-count.
// - PC family, action 01 toggles channel A only in modes 8-11.
// - Waveform mode is control B bits 4:3 above control A bits 1:0.
// - Mode 0 normal count to 0xFFFF, immediate update, overflow at MAX.
// - Modes 1-3 phase correct, TOP 0xFF/0x1FF/0x3FF, update TOP, overflow BOTTOM.
// - Modes 5-7, 14, 15 fast PWM; update at TOP, overflow at TOP.
// - Modes 4, 12 clear-on-match; mode 4 TOP is compare A; immediate update.
// - Modes 8, 9 PFC PWM, TOP capture/compare A, update and overflow BOTTOM.
// - Modes 10, 11 phase correct, TOP capture/compare A, update TOP.
// - Filter enabled changes level only after four equal samples.
// - Edge select zero captures falling edge, one captures rising edge.
// - Selected capture edge copies counter value and raises capture event.
// - While capture register is TOP, capture input is ignored.
// - Clock select 0 stops; 1-5 divide I/O clock by 1/8/64/256/1024.
// - Clock select 6 and 7 count external falling or rising edges.
// - External edges count even when that pin is driven as an output.
// - Force strobe acts as a match with present action, non-PWM modes only.
// - Forced match sets no flag and does not clear the counter.
// - Force bits are write strobes and always read zero.
package tmc_pkg;
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_FORCE  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] CTRLB_WMASK = 8'hdf;
  localparam int CTRLB_FILT   = 7;
  localparam int CTRLB_EDGE   = 6;
  localparam int CTRLB_WGM_LO = 3;
  localparam int CTRLB_CS_LO  = 0;
  localparam int CTRLA_WGM_LO = 0;
  localparam int CTRLA_COM_A  = 6;
  localparam int FORCE_A      = 7;
  localparam logic [15:0] TOP_MAX  = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV64_MASK   = 10'h03f;
  localparam logic [9:0] DIV256_MASK  = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam int FILTER_LEN = 4;
  typedef enum {KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PC, KIND_PFC}
    tmc_kind_t;
  typedef enum logic [1:0] {EV_IMMEDIATE, EV_MAX, EV_TOP, EV_BOTTOM}
    tmc_event_t;
endpackage

// ==== tmc_capture_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_capture_filter (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic filterEn,
  input  wire logic levelIn,
  output var  logic levelOut
);
  logic [tmc_pkg::FILTER_LEN-1:0] hist_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hist_reg <= '0;
    end else begin
      hist_reg <= {hist_reg[tmc_pkg::FILTER_LEN-2:0], levelIn};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      levelOut <= 1'b0;
    end else if (!filterEn) begin
      levelOut <= levelIn;
    end else if (&hist_reg || ~|hist_reg) begin
      levelOut <= hist_reg[0];
    end
  end

  a_filter_four_equal: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(filterEn) && $changed(levelOut)
      |-> $past(&hist_reg || ~|hist_reg))
    else $error("filtered level changed without four equal samples");
endmodule // tmc_capture_filter
`default_nettype wire

// ==== tmc_mode_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tmc_mode_ctrl (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic               extCountPin,
  input  wire logic               capturePin,
  input  wire logic [15:0]        counterValue,
  input  wire logic [15:0]        compareValueA,
  input  wire logic [15:0]        captureValue,
  input  wire logic [2:0]         matchIn,
  input  wire logic               atTop,
  input  wire logic               countingDown,
  output var  logic [3:0]         waveformMode,
  output var  tmc_pkg::tmc_kind_t modeKind,
  output var  logic [15:0]        topValue,
  output var  tmc_pkg::tmc_event_t updateEvent,
  output var  tmc_pkg::tmc_event_t overflowEvent,
  output var  logic               clearOnTop,
  output var  logic               countTick,
  output var  logic               captureLoad,
  output var  logic [15:0]        captureSnapshot,
  output var  logic [2:0]         compareOut,
  output var  logic [2:0]         compareOutEn
);
  logic [7:0]  ctrlA_reg;
  logic [7:0]  ctrlB_reg;
  logic [2:0]  forcePulse_reg;
  logic [9:0]  prescale_reg;
  logic [1:0]  extSync_reg;
  logic        extPrev_reg;
  logic [1:0]  capSync_reg;
  logic        capFilt;
  logic        capPrev_reg;
  logic        accessDone;
  logic        wrStrobe;
  logic [3:0]  modeNext;
  logic [2:0]  clkSel;
  logic        nonPwm;
  logic        pcFamily;
  logic        topIsCapture;
  logic        toggleAOk;
  logic        prescaleHit;
  logic        extRise;
  logic        extFall;
  logic        capEdge;
  tmc_pkg::tmc_kind_t  kindNext;
  tmc_pkg::tmc_event_t updNext;
  tmc_pkg::tmc_event_t ovfNext;
  logic [15:0] topNext;

  assign accessDone = psel && penable && pready;
  assign wrStrobe   = accessDone && pwrite;
  assign clkSel     = ctrlB_reg[tmc_pkg::CTRLB_CS_LO +: 3];
  assign modeNext   = {ctrlB_reg[tmc_pkg::CTRLB_WGM_LO +: 2],
                       ctrlA_reg[tmc_pkg::CTRLA_WGM_LO +: 2]};

  // Mode table: sequence kind, TOP, compare update and overflow point
  always_comb begin
    kindNext     = tmc_pkg::KIND_NORMAL;
    topNext      = tmc_pkg::TOP_MAX;
    updNext      = tmc_pkg::EV_IMMEDIATE;
    ovfNext      = tmc_pkg::EV_MAX;
    topIsCapture = 1'b0;
    case (modeNext)
      4'h0: begin
        kindNext = tmc_pkg::KIND_NORMAL;
      end
      4'h1, 4'h2, 4'h3: begin
        kindNext = tmc_pkg::KIND_PC;
        updNext  = tmc_pkg::EV_TOP;
        ovfNext  = tmc_pkg::EV_BOTTOM;
      end
      4'h4: begin
        kindNext = tmc_pkg::KIND_CTC;
        topNext  = compareValueA;
      end
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
        kindNext = tmc_pkg::KIND_FAST;
        updNext  = tmc_pkg::EV_TOP;
        ovfNext  = tmc_pkg::EV_TOP;
      end
      4'h8, 4'h9: begin
        kindNext = tmc_pkg::KIND_PFC;
        updNext  = tmc_pkg::EV_BOTTOM;
        ovfNext  = tmc_pkg::EV_BOTTOM;
      end
      4'ha, 4'hb: begin
        kindNext = tmc_pkg::KIND_PC;
        updNext  = tmc_pkg::EV_TOP;
        ovfNext  = tmc_pkg::EV_BOTTOM;
      end
      4'hc: begin
        kindNext     = tmc_pkg::KIND_CTC;
        topNext      = captureValue;
        topIsCapture = 1'b1;
      end
      default: begin
        kindNext = tmc_pkg::KIND_NORMAL;
      end
    endcase
    case (modeNext)
      4'h1, 4'h5: topNext = tmc_pkg::TOP_8BIT;
      4'h2, 4'h6: topNext = tmc_pkg::TOP_9BIT;
      4'h3, 4'h7: topNext = tmc_pkg::TOP_10BIT;
      4'h8, 4'ha, 4'he: begin
        topNext      = captureValue;
        topIsCapture = 1'b1;
      end
      4'h9, 4'hb, 4'hf: topNext = compareValueA;
      default: ;
    endcase
  end

  assign nonPwm   = (kindNext == tmc_pkg::KIND_NORMAL) ||
                    (kindNext == tmc_pkg::KIND_CTC);
  assign pcFamily = (kindNext == tmc_pkg::KIND_PC) ||
                    (kindNext == tmc_pkg::KIND_PFC);
  assign toggleAOk = nonPwm ||
                     (modeNext >= 4'h8 && modeNext <= 4'hb) ||
                     (modeNext == 4'he) || (modeNext == 4'hf);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      waveformMode  <= 4'h0;
      modeKind      <= tmc_pkg::KIND_NORMAL;
      topValue      <= tmc_pkg::TOP_MAX;
      updateEvent   <= tmc_pkg::EV_IMMEDIATE;
      overflowEvent <= tmc_pkg::EV_MAX;
      clearOnTop    <= 1'b0;
    end else begin
      waveformMode  <= modeNext;
      modeKind      <= kindNext;
      topValue      <= topNext;
      updateEvent   <= updNext;
      overflowEvent <= ovfNext;
      clearOnTop    <= (kindNext == tmc_pkg::KIND_CTC);
    end
  end

  // APB slave: access phase answered on its second cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        case (paddr)
          tmc_pkg::ADDR_CTRL_A: prdata <= {24'h000000, ctrlA_reg};
          tmc_pkg::ADDR_CTRL_B: prdata <= {24'h000000, ctrlB_reg};
          tmc_pkg::ADDR_FORCE:  prdata <= 32'h0000_0000;
          tmc_pkg::ADDR_STATUS:
            prdata <= {21'h000000, capFilt, compareOutEn,
                       compareOut, waveformMode};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlA_reg <= tmc_pkg::CTRL_RESET;
      ctrlB_reg <= tmc_pkg::CTRL_RESET;
    end else if (wrStrobe) begin
      if (paddr == tmc_pkg::ADDR_CTRL_A) begin
        ctrlA_reg <= pwdata[7:0];
      end
      if (paddr == tmc_pkg::ADDR_CTRL_B) begin
        ctrlB_reg <= pwdata[7:0] & tmc_pkg::CTRLB_WMASK;
      end
    end
  end

  // Force bits are strobes only, dropped in PWM modes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      forcePulse_reg <= 3'h0;
    end else if (wrStrobe && paddr == tmc_pkg::ADDR_FORCE && nonPwm) begin
      forcePulse_reg <= {pwdata[tmc_pkg::FORCE_A-2],
                         pwdata[tmc_pkg::FORCE_A-1],
                         pwdata[tmc_pkg::FORCE_A]};
    end else begin
      forcePulse_reg <= 3'h0;
    end
  end

  // Count clock: prescaler or synchronised external pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prescale_reg <= 10'h000;
      extSync_reg  <= 2'b00;
      extPrev_reg  <= 1'b0;
    end else begin
      prescale_reg <= prescale_reg + 10'h001;
      extSync_reg  <= {extSync_reg[0], extCountPin};
      extPrev_reg  <= extSync_reg[1];
    end
  end

  assign extRise = extSync_reg[1] && !extPrev_reg;
  assign extFall = !extSync_reg[1] && extPrev_reg;

  always_comb begin
    case (clkSel)
      tmc_pkg::CS_DIV8:
        prescaleHit = (prescale_reg & tmc_pkg::DIV8_MASK) ==
                      tmc_pkg::DIV8_MASK;
      tmc_pkg::CS_DIV64:
        prescaleHit = (prescale_reg & tmc_pkg::DIV64_MASK) ==
                      tmc_pkg::DIV64_MASK;
      tmc_pkg::CS_DIV256:
        prescaleHit = (prescale_reg & tmc_pkg::DIV256_MASK) ==
                      tmc_pkg::DIV256_MASK;
      tmc_pkg::CS_DIV1024:
        prescaleHit = prescale_reg == tmc_pkg::DIV1024_MASK;
      default: prescaleHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      countTick <= 1'b0;
    end else begin
      case (clkSel)
        tmc_pkg::CS_STOP:     countTick <= 1'b0;
        tmc_pkg::CS_DIV1:     countTick <= 1'b1;
        tmc_pkg::CS_EXT_FALL: countTick <= extFall;
        tmc_pkg::CS_EXT_RISE: countTick <= extRise;
        default:              countTick <= prescaleHit;
      endcase
    end
  end

  // Input capture path
  always_ff @(posedge core_clk) begin
    if (rst) begin
      capSync_reg <= 2'b00;
      capPrev_reg <= 1'b0;
    end else begin
      capSync_reg <= {capSync_reg[0], capturePin};
      capPrev_reg <= capFilt;
    end
  end

  tmc_capture_filter u_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .filterEn (ctrlB_reg[tmc_pkg::CTRLB_FILT]),
    .levelIn  (capSync_reg[1]),
    .levelOut (capFilt)
  );

  assign capEdge = ctrlB_reg[tmc_pkg::CTRLB_EDGE] ?
                   (capFilt && !capPrev_reg) :
                   (!capFilt && capPrev_reg);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      captureLoad     <= 1'b0;
      captureSnapshot <= 16'h0000;
    end else begin
      captureLoad <= capEdge && !topIsCapture;
      if (capEdge && !topIsCapture) begin
        captureSnapshot <= counterValue;
      end
    end
  end

  // Compare output units, one per channel
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_out
      logic [1:0] act;
      logic       hit;
      logic       outNext;
      logic       enNext;
      assign act = ctrlA_reg[tmc_pkg::CTRLA_COM_A - 2*ch +: 2];
      // A forced match only moves the pin: no flag, no counter clear
      assign hit = matchIn[ch] || forcePulse_reg[ch];

      always_comb begin
        outNext = compareOut[ch];
        enNext  = act != tmc_pkg::ACT_OFF;
        if (act == tmc_pkg::ACT_TOGGLE &&
            !(nonPwm || (ch == 0 && toggleAOk))) begin
          enNext = 1'b0;
        end
        if (act == tmc_pkg::ACT_OFF) begin
          enNext = 1'b0;
        end else if (pcFamily) begin
          if (matchIn[ch]) begin
            case (act)
              tmc_pkg::ACT_CLEAR: outNext = countingDown;
              tmc_pkg::ACT_SET:   outNext = !countingDown;
              default:            outNext = enNext ? !compareOut[ch]
                                                   : compareOut[ch];
            endcase
          end
        end else if (kindNext == tmc_pkg::KIND_FAST) begin
          if (matchIn[ch]) begin
            case (act)
              tmc_pkg::ACT_CLEAR: outNext = 1'b0;
              tmc_pkg::ACT_SET:   outNext = 1'b1;
              default:            outNext = enNext ? !compareOut[ch]
                                                   : compareOut[ch];
            endcase
          end
          if (atTop && act == tmc_pkg::ACT_CLEAR) begin
            outNext = 1'b1;
          end
          if (atTop && act == tmc_pkg::ACT_SET) begin
            outNext = 1'b0;
          end
        end else if (hit) begin
          case (act)
            tmc_pkg::ACT_CLEAR: outNext = 1'b0;
            tmc_pkg::ACT_SET:   outNext = 1'b1;
            default:            outNext = !compareOut[ch];
          endcase
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          compareOut[ch]   <= 1'b0;
          compareOutEn[ch] <= 1'b0;
        end else begin
          compareOut[ch]   <= outNext;
          compareOutEn[ch] <= enNext;
        end
      end
    end
  endgenerate

  sequence s_pc_up_match(logic [1:0] a);
    pcFamily && matchIn[0] && !countingDown &&
      ctrlA_reg[tmc_pkg::CTRLA_COM_A +: 2] == a;
  endsequence

  a_pc_clear_up: assert property (
    @(posedge core_clk) disable iff (rst)
    s_pc_up_match(tmc_pkg::ACT_CLEAR) |=> !compareOut[0])
    else $error("action 10 did not clear on up-count match");

  a_pc_set_up: assert property (
    @(posedge core_clk) disable iff (rst)
    s_pc_up_match(tmc_pkg::ACT_SET) |=> compareOut[0])
    else $error("action 11 did not set on up-count match");

  a_pc_disconnect: assert property (
    @(posedge core_clk) disable iff (rst)
    pcFamily && ctrlA_reg[tmc_pkg::CTRLA_COM_A +: 2] == tmc_pkg::ACT_OFF
      |=> !compareOutEn[0])
    else $error("output enabled with action 00");

  a_toggle_b_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !nonPwm && ctrlA_reg[tmc_pkg::CTRLA_COM_A-2 +: 2] == 2'h1
      |=> !compareOutEn[1])
    else $error("channel B toggle connected in PWM mode");

  a_mode_compose: assert property (
    @(posedge core_clk) disable iff (rst)
    ##1 waveformMode == {$past(ctrlB_reg[4:3]), $past(ctrlA_reg[1:0])})
    else $error("waveform mode not formed from control bits");

  a_stop_no_tick: assert property (
    @(posedge core_clk) disable iff (rst)
    (clkSel == tmc_pkg::CS_STOP) [*2] |-> !countTick)
    else $error("count tick while clock stopped");

  a_ext_rise_tick: assert property (
    @(posedge core_clk) disable iff (rst)
    clkSel == tmc_pkg::CS_EXT_RISE && extRise |=> countTick)
    else $error("external rising edge did not tick");

  a_force_pwm_drop: assert property (
    @(posedge core_clk) disable iff (rst)
    forcePulse_reg != 3'h0 |-> $past(nonPwm))
    else $error("force strobe accepted in PWM mode");

  a_capture_copy: assert property (
    @(posedge core_clk) disable iff (rst)
    captureLoad |-> captureSnapshot == $past(counterValue))
    else $error("capture did not copy counter value");

  a_capture_block: assert property (
    @(posedge core_clk) disable iff (rst)
    $past(topIsCapture) |-> !captureLoad)
    else $error("capture taken while capture register is TOP");

  a_force_read_zero: assert property (
    @(posedge core_clk) disable iff (rst)
    pready && !pwrite && paddr == tmc_pkg::ADDR_FORCE |-> prdata == 0)
    else $error("force register read nonzero");
endmodule // tmc_mode_ctrl
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  logic                extCountPin, capturePin, atTop, countingDown;
  logic [15:0]         counterValue, compareValueA, captureValue;
  logic [2:0]          matchIn, compareOut, compareOutEn;
  logic [3:0]          waveformMode;
  tmc_pkg::tmc_kind_t  modeKind;
  tmc_pkg::tmc_event_t updateEvent, overflowEvent;
  logic [15:0]         topValue, captureSnapshot;
  logic                clearOnTop, countTick, captureLoad;
  int                  errorCnt, cmpCount;

  tmc_mode_ctrl DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extCountPin(extCountPin), .capturePin(capturePin),
    .counterValue(counterValue), .compareValueA(compareValueA),
    .captureValue(captureValue), .matchIn(matchIn), .atTop(atTop),
    .countingDown(countingDown), .waveformMode(waveformMode),
    .modeKind(modeKind), .topValue(topValue), .updateEvent(updateEvent),
    .overflowEvent(overflowEvent), .clearOnTop(clearOnTop),
    .countTick(countTick), .captureLoad(captureLoad),
    .captureSnapshot(captureSnapshot), .compareOut(compareOut),
    .compareOutEn(compareOutEn));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic endOfTest();
    if (errorCnt == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(ex));
  endtask

  // act holds the three action fields, fe the filter and edge bits
  task automatic setMode(input logic [3:0] m, input logic [5:0] act,
      input logic [1:0] fe, input logic [2:0] cs);
    wr(tmc_pkg::ADDR_CTRL_A, {24'h0, act, m[1:0]});
    wr(tmc_pkg::ADDR_CTRL_B, {24'h0, fe, 1'b0, m[3:2], cs});
    repeat (3) @(posedge core_clk);
  endtask

  task automatic ticks(input int k, inout int n);
    repeat (k) begin
      @(posedge core_clk);
      if (countTick === 1'b1) n++;
    end
  endtask

  task automatic testRegs();
    rd(tmc_pkg::ADDR_CTRL_B, 32'h0, 1'b0);
    rd(tmc_pkg::ADDR_FORCE, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(tmc_pkg::ADDR_CTRL_B, 32'hdf);
    rd(tmc_pkg::ADDR_CTRL_B, 32'hdf, 1'b0);
    wr(tmc_pkg::ADDR_CTRL_B, 32'h0);
    wr(tmc_pkg::ADDR_FORCE, 32'he0);
    rd(tmc_pkg::ADDR_FORCE, 32'h0, 1'b0);
  endtask

  task automatic testModes();
    tmc_pkg::tmc_kind_t  k;
    tmc_pkg::tmc_event_t u, o;
    logic [15:0]         t;
    for (int m = 0; m < 16; m++) begin
      if (m == 13) continue;
      setMode(4'(m), 6'h0, 2'b00, tmc_pkg::CS_STOP);
      k = (m == 0 || m == 13) ? tmc_pkg::KIND_NORMAL :
          (m == 4 || m == 12) ? tmc_pkg::KIND_CTC :
          (m == 8 || m == 9) ? tmc_pkg::KIND_PFC :
          (m inside {[5:7], 14, 15}) ? tmc_pkg::KIND_FAST : tmc_pkg::KIND_PC;
      case (m)
        0, 13: t = tmc_pkg::TOP_MAX;
        1, 5: t = tmc_pkg::TOP_8BIT;
        2, 6: t = tmc_pkg::TOP_9BIT;
        3, 7: t = tmc_pkg::TOP_10BIT;
        4, 9, 11, 15: t = compareValueA;
        default: t = captureValue;
      endcase
      u = (k == tmc_pkg::KIND_NORMAL || k == tmc_pkg::KIND_CTC) ?
          tmc_pkg::EV_IMMEDIATE : (k == tmc_pkg::KIND_PFC) ?
          tmc_pkg::EV_BOTTOM : tmc_pkg::EV_TOP;
      o = (k == tmc_pkg::KIND_NORMAL || k == tmc_pkg::KIND_CTC) ?
          tmc_pkg::EV_MAX : (k == tmc_pkg::KIND_FAST) ?
          tmc_pkg::EV_TOP : tmc_pkg::EV_BOTTOM;
      chk(32'(waveformMode), 32'(m));
      chk(32'(modeKind), 32'(k));
      chk(32'(topValue), 32'(t));
      chk(32'(updateEvent), 32'(u));
      chk(32'(overflowEvent), 32'(o));
      chk(32'(clearOnTop), 32'(m == 4 || m == 12));
    end
  endtask

  task automatic testClock();
    int exp[6] = '{0, 2048, 256, 32, 8, 2};
    int n;
    for (int cs = 0; cs < 6; cs++) begin
      setMode(4'h0, 6'h0, 2'b00, 3'(cs));
      repeat (8) @(posedge core_clk);
      n = 0;
      ticks(2048, n);
      chk(32'(n), 32'(exp[cs]));
    end
  endtask

  // Seven pin toggles from low: four rising and three falling edges
  task automatic extRun(input logic [2:0] cs, input int exp);
    int n;
    n = 0;
    setMode(4'h0, 6'h0, 2'b00, cs);
    repeat (7) begin
      extCountPin <= ~extCountPin;
      ticks(6, n);
    end
    ticks(8, n);
    chk(32'(n), 32'(exp));
    setMode(4'h0, 6'h0, 2'b00, tmc_pkg::CS_STOP);
    extCountPin <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic capEdge(input logic lvl, output int lat);
    capturePin <= lvl;
    lat = 99;
    for (int i = 1; i <= 16; i++) begin
      @(posedge core_clk);
      if (captureLoad === 1'b1 && lat == 99) begin
        lat = i;
        chk(32'(captureSnapshot), 32'(counterValue));
      end
    end
  endtask

  task automatic testCapture();
    int l1, l;
    setMode(4'h0, 6'h0, 2'b01, tmc_pkg::CS_STOP);
    capEdge(1'b1, l1);
    chk(32'(l1 < 16), 32'h1);
    capEdge(1'b0, l);
    chk(32'(l), 32'd99);
    setMode(4'h0, 6'h0, 2'b00, tmc_pkg::CS_STOP);
    capEdge(1'b1, l);
    chk(32'(l), 32'd99);
    capEdge(1'b0, l);
    chk(32'(l < 16), 32'h1);
    setMode(4'h0, 6'h0, 2'b11, tmc_pkg::CS_STOP);
    capturePin <= 1'b1;
    repeat (2) @(posedge core_clk);
    capEdge(1'b0, l);
    chk(32'(l), 32'd99);
    capEdge(1'b1, l);
    chk(32'(l), 32'(l1 + 4));
    for (int m = 8; m <= 14; m += 2) begin
      setMode(4'(m), 6'h0, 2'b01, tmc_pkg::CS_STOP);
      capEdge(1'b0, l);
      capEdge(1'b1, l);
      chk(32'(l), 32'd99);
    end
  endtask

  task automatic matchEv(input logic [2:0] ch, input logic dn);
    matchIn <= ch;
    countingDown <= dn;
    @(posedge core_clk);
    matchIn <= 3'b000;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic testPwm();
    setMode(4'h1, 6'h0, 2'b00, tmc_pkg::CS_STOP);
    chk(32'(compareOutEn), 32'h0);
    setMode(4'h1, 6'h28, 2'b00, tmc_pkg::CS_STOP);
    chk(32'(compareOutEn), 32'h3);
    matchEv(3'b011, 1'b1);
    chk(32'(compareOut[1:0]), 32'h3);
    matchEv(3'b011, 1'b0);
    chk(32'(compareOut[1:0]), 32'h0);
    setMode(4'h1, 6'h3c, 2'b00, tmc_pkg::CS_STOP);
    matchEv(3'b011, 1'b0);
    chk(32'(compareOut[1:0]), 32'h3);
    matchEv(3'b011, 1'b1);
    chk(32'(compareOut[1:0]), 32'h0);
    setMode(4'h1, 6'h14, 2'b00, tmc_pkg::CS_STOP);
    chk(32'(compareOutEn), 32'h0);
    setMode(4'h8, 6'h0, 2'b00, tmc_pkg::CS_STOP);
    chk(32'(compareOutEn), 32'h0);
    setMode(4'h9, 6'h14, 2'b00, tmc_pkg::CS_STOP);
    chk(32'(compareOutEn), 32'h1);
    matchEv(3'b001, 1'b0);
    chk(32'(compareOut[0]), 32'h1);
    matchEv(3'b001, 1'b1);
    chk(32'(compareOut[0]), 32'h0);
  endtask

  task automatic frc(input logic [3:0] m, input logic [5:0] act,
      input logic [2:0] exp);
    setMode(m, act, 2'b00, tmc_pkg::CS_STOP);
    wr(tmc_pkg::ADDR_FORCE, 32'he0);
    repeat (3) @(posedge core_clk);
    chk(32'(compareOut), 32'(exp));
  endtask

  task automatic testForce();
    frc(4'h0, 6'h3f, 3'b111);
    frc(4'h4, 6'h20, 3'b110);
    frc(4'h4, 6'h10, 3'b111);
    frc(4'h4, 6'h10, 3'b110);
    chk(32'(clearOnTop), 32'h1);
    frc(4'h5, 6'h30, 3'b110);
  endtask

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; extCountPin = 1'b0; capturePin = 1'b0;
    counterValue = 16'h5a5a; compareValueA = 16'h1234;
    captureValue = 16'h0abc; matchIn = 3'b000; atTop = 1'b0;
    countingDown = 1'b0; errorCnt = 0; cmpCount = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    testRegs();
    testModes();
    testClock();
    extRun(tmc_pkg::CS_EXT_RISE, 4);
    extRun(tmc_pkg::CS_EXT_FALL, 3);
    testCapture();
    testPwm();
    testForce();
    endOfTest();
  end

  // Cuts a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge core_clk);
    errorCnt++;
    endOfTest();
  end
endmodule // tb_top
`default_nettype wire
